// File: src/eeps_pkg.sv
// shared constants and types for the serial eeprom slave and its bus master
package eeps_pkg;
    // fixed upper nibble of the slave address byte
    localparam logic [3:0] EEPS_PREFIX = 4'ha;
    // page geometry and byte framing
    localparam int EEPS_PAGE_SIZE = 16;
    localparam logic [3:0] EEPS_LAST_BIT = 4'h7;
    localparam logic [3:0] EEPS_ACK_BIT = 4'h8;
    localparam logic [7:0] EEPS_ERASED = 8'hff;
    // system clock rate and the internal write cycle time
    localparam int EEPS_SYS_CLK_KHZ = 20000;
    localparam int EEPS_WR_TIME_MS = 5;
    localparam int EEPS_WR_CYC = EEPS_WR_TIME_MS * EEPS_SYS_CLK_KHZ;
    // serial clock made by the master: four quarters per period, rounded up
    localparam int EEPS_SCL_KHZ = 100;
    localparam int EEPS_QTR_CYC = (EEPS_SYS_CLK_KHZ + 4 * EEPS_SCL_KHZ - 1) / (4 * EEPS_SCL_KHZ);

    typedef enum logic [1:0] {
        eeps_cmd_start,
        eeps_cmd_stop,
        eeps_cmd_write,
        eeps_cmd_read
    } eeps_cmd_t;

    typedef enum logic [2:0] {
        eeps_st_idle,
        eeps_st_addr,
        eeps_st_waddr,
        eeps_st_wdata,
        eeps_st_rdata
    } eeps_dst_t;

    typedef enum logic [1:0] {
        eeps_hs_idle,
        eeps_hs_start,
        eeps_hs_bit,
        eeps_hs_stop
    } eeps_hst_t;
endpackage

// File: src/eeps_if.sv
// two-wire bus between the eeprom slave and the master
interface eeps_if;
    logic scl;
    logic host_sda_oe;
    logic dev_sda_oe;
    logic sda;

    // wired-and data line with pull-up: any enabled driver pulls it low
    assign sda = ~(host_sda_oe | dev_sda_oe);

    modport dev (input scl, input sda, output dev_sda_oe);
    modport host (output scl, output host_sda_oe, input sda);
endinterface

// File: src/eeps_dev.sv
// serial eeprom slave: link-clocked protocol engine and system-clocked write cycle
// Functional notes
// R01: address byte must start with 1010
// R02: address lsb one reads, zero writes
// R03: middle bits match pins or select block
// R04: matched address acked low in ninth period
// R05: write address and bytes acked unless rejected
// R06: read eight bits, release ninth, continue on ack
// R07: sda change only scl low; start/stop edges
// R08: ignore all traffic until start seen
// R09: sample on scl rise, drive after fall
// R10: data output is open drain
// R11: byte write: address, pointer, data, stop commits
// R12: silent during internal write cycle
// R13: page write, low four bits increment
// R14: over sixteen bytes wraps within page
// R15: ack polling: nack while busy, ack after
// R16: write protect sampled before first data byte
// R17: read without pointer uses current address
// R18: random read: dummy write, restart, read
// R19: sequential read wraps at memory end
// R20: smallest size counter does not wrap at 128
// R21: memory erased to all ones
// R22: reset models power-on and brown-out
// R23: pointer kept across repeated start
module eeps_dev import eeps_pkg::*; #(
    parameter int MEM_AW = 11,
    parameter int WR_CYC = EEPS_WR_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    eeps_if.dev bus,
    input wire logic addr_select_pin0,
    input wire logic addr_select_pin1,
    input wire logic addr_select_pin2,
    input wire logic wp,
    output logic write_busy
);
    localparam int INT_BITS = (MEM_AW > 8) ? MEM_AW - 8 : 0;
    localparam int PTR_W = (MEM_AW > 8) ? MEM_AW : 8;
    localparam int CW = $clog2(WR_CYC + 1);
    localparam logic [2:0] INT_MASK = 3'((1 << INT_BITS) - 1);

    // link domain state
    logic start_tog_reg;
    logic stop_tog_reg;
    logic start_seen_reg;
    eeps_dst_t state_reg;
    logic [3:0] cnt_reg;
    logic [7:0] sh_reg;
    logic [7:0] byte_reg;
    logic ack_reg;
    logic pend_reg;
    logic first_reg;
    logic sda_oe_reg;
    logic wp_s1_reg;
    logic wp_s2_reg;
    logic wp_lat_reg;
    logic [2:0] pins_s1_reg;
    logic [2:0] pins_s2_reg;
    logic busy_s1_reg;
    logic busy_s2_reg;
    logic [PTR_W-1:0] ptr_reg;
    logic [EEPS_PAGE_SIZE-1:0] pmask_reg;
    logic [7:0] pbuf [EEPS_PAGE_SIZE];
    // system domain state
    logic stop_s1_reg;
    logic stop_s2_reg;
    logic stop_s3_reg;
    logic pend_s1_reg;
    logic pend_s2_reg;
    logic busy_reg;
    logic [CW-1:0] wcyc_reg;
    logic [7:0] mem [2**MEM_AW];

    // decode of the byte being received and of the next drive level
    wire logic new_start = start_tog_reg ^ start_seen_reg;
    wire logic [7:0] byte_next = {sh_reg[6:0], bus.sda};
    wire logic prefix_ok = (byte_next[7:4] == EEPS_PREFIX); // [R01]
    wire logic pins_ok = (((byte_next[3:1] ^ pins_s2_reg) & ~INT_MASK) == 3'h0); // [R03]
    wire logic addr_match = prefix_ok & pins_ok & ~busy_s2_reg; // [R12] [R15]
    wire logic is_read = byte_reg[0]; // [R02]
    wire logic ack_next = (state_reg == eeps_st_addr) ? addr_match :
                          (state_reg == eeps_st_waddr) ? 1'b1 :
                          (state_reg == eeps_st_wdata) ? ~wp_lat_reg : 1'b0; // [R05] [R16]
    wire logic [PTR_W-1:0] ptr_inc = ptr_reg + PTR_W'(1); // [R19] [R20]
    wire logic [3:0] pg_inc = ptr_reg[3:0] + 4'h1; // [R13] [R14]
    wire logic [7:0] rd_byte = mem[ptr_reg[MEM_AW-1:0]];
    wire logic [2:0] bit_sel = 3'h7 - cnt_reg[2:0];
    wire logic oe_next = (cnt_reg == EEPS_ACK_BIT) ? ack_reg :
                         (state_reg == eeps_st_rdata) ? ~rd_byte[bit_sel] : 1'b0; // [R06] [R10]
    wire logic at_ack = (state_reg != eeps_st_idle) && !new_start && (cnt_reg == EEPS_ACK_BIT);
    wire logic buf_we = at_ack && (state_reg == eeps_st_wdata) && ack_reg;
    wire logic stop_evt = stop_s2_reg ^ stop_s3_reg;
    wire logic commit = stop_evt & pend_s2_reg & ~busy_reg; // [R11]
    wire logic [MEM_AW-5:0] page = ptr_reg[MEM_AW-1:4];
    logic [PTR_W-1:0] ptr_blk;
    logic [PTR_W-1:0] ptr_low;

    // block bits from the address byte and byte address into the pointer
    generate
        if (INT_BITS > 0) begin : g_blk
            assign ptr_blk = {byte_reg[INT_BITS:1], ptr_reg[7:0]}; // [R03]
            assign ptr_low = {ptr_reg[PTR_W-1:8], byte_reg};
        end else begin : g_noblk
            assign ptr_blk = ptr_reg;
            assign ptr_low = byte_reg;
        end
    endgenerate

    assign bus.dev_sda_oe = sda_oe_reg;
    assign write_busy = busy_reg;

    // start: sda falls while scl high
    always_ff @(negedge bus.sda or posedge rst) begin
        if (rst) begin
            start_tog_reg <= 1'b0;
        end else if (bus.scl) begin
            start_tog_reg <= ~start_tog_reg; // [R07]
        end
    end

    // stop: sda rises while scl high
    always_ff @(posedge bus.sda or posedge rst) begin
        if (rst) begin
            stop_tog_reg <= 1'b0;
        end else if (bus.scl) begin
            stop_tog_reg <= ~stop_tog_reg; // [R07]
        end
    end

    // synchronisers into the link domain
    always_ff @(posedge bus.scl or posedge rst) begin
        if (rst) begin
            pins_s1_reg <= 3'h0;
            pins_s2_reg <= 3'h0;
            busy_s1_reg <= 1'b0;
            busy_s2_reg <= 1'b0;
        end else begin
            pins_s1_reg <= {addr_select_pin2, addr_select_pin1, addr_select_pin0};
            pins_s2_reg <= pins_s1_reg;
            busy_s1_reg <= busy_reg;
            busy_s2_reg <= busy_s1_reg;
        end
    end

    // bit counter and byte capture on the rising edge
    always_ff @(posedge bus.scl or posedge rst) begin
        if (rst) begin
            start_seen_reg <= 1'b0;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            byte_reg <= 8'h00;
            ack_reg <= 1'b0;
        end else begin
            sh_reg <= byte_next; // [R09]
            if (new_start) begin
                start_seen_reg <= start_tog_reg;
                cnt_reg <= 4'h1;
            end else if (state_reg != eeps_st_idle) begin
                if (cnt_reg == EEPS_LAST_BIT) begin
                    byte_reg <= byte_next;
                    ack_reg <= ack_next; // [R04]
                    cnt_reg <= EEPS_ACK_BIT;
                end else if (cnt_reg == EEPS_ACK_BIT) begin
                    cnt_reg <= 4'h0;
                end else begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end
        end
    end

    // command sequencing at the ninth rising edge of each byte
    always_ff @(posedge bus.scl or posedge rst) begin
        if (rst) begin
            state_reg <= eeps_st_idle;
            ptr_reg <= '0;
            pend_reg <= 1'b0;
            first_reg <= 1'b0;
            pmask_reg <= '0;
        end else if (new_start) begin
            state_reg <= eeps_st_addr; // [R08] [R23]
            pend_reg <= 1'b0;
        end else if (at_ack) begin
            case (state_reg)
                eeps_st_addr: begin
                    if (!ack_reg) begin
                        state_reg <= eeps_st_idle; // [R01] [R12]
                    end else if (is_read) begin
                        state_reg <= eeps_st_rdata; // [R17]
                    end else begin
                        state_reg <= eeps_st_waddr;
                        ptr_reg <= ptr_blk;
                    end
                end
                eeps_st_waddr: begin
                    state_reg <= eeps_st_wdata;
                    ptr_reg <= ptr_low; // [R11]
                    first_reg <= 1'b1;
                    pmask_reg <= '0;
                end
                eeps_st_wdata: begin
                    if (ack_reg) begin
                        ptr_reg[3:0] <= pg_inc; // [R13] [R14]
                        pmask_reg[ptr_reg[3:0]] <= 1'b1;
                        pend_reg <= 1'b1;
                        first_reg <= 1'b0;
                    end else begin
                        state_reg <= eeps_st_idle; // [R16]
                        pend_reg <= 1'b0;
                    end
                end
                eeps_st_rdata: begin
                    ptr_reg <= ptr_inc; // [R19]
                    if (bus.sda) begin
                        state_reg <= eeps_st_idle; // [R06] [R17]
                    end
                end
                default: begin
                    state_reg <= eeps_st_idle;
                end
            endcase
        end
    end

    // page buffer, later overwrites land on the same slot
    always_ff @(posedge bus.scl) begin
        if (buf_we) begin
            pbuf[ptr_reg[3:0]] <= byte_reg; // [R14]
        end
    end

    // drive and write-protect strobe on the falling edge
    always_ff @(negedge bus.scl or posedge rst) begin
        if (rst) begin
            sda_oe_reg <= 1'b0;
            wp_s1_reg <= 1'b0;
            wp_s2_reg <= 1'b0;
            wp_lat_reg <= 1'b0;
        end else begin
            sda_oe_reg <= oe_next; // [R09] [R10]
            wp_s1_reg <= wp;
            wp_s2_reg <= wp_s1_reg;
            if (state_reg == eeps_st_wdata && cnt_reg == 4'h0 && first_reg) begin
                wp_lat_reg <= wp_s2_reg; // [R16]
            end
        end
    end

    // internal write timer in the system domain
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stop_s1_reg <= 1'b0;
            stop_s2_reg <= 1'b0;
            stop_s3_reg <= 1'b0;
            pend_s1_reg <= 1'b0;
            pend_s2_reg <= 1'b0;
            busy_reg <= 1'b0; // [R22]
            wcyc_reg <= '0;
        end else begin
            stop_s1_reg <= stop_tog_reg;
            stop_s2_reg <= stop_s1_reg;
            stop_s3_reg <= stop_s2_reg;
            pend_s1_reg <= pend_reg;
            pend_s2_reg <= pend_s1_reg;
            if (commit) begin
                busy_reg <= 1'b1; // [R12]
                wcyc_reg <= CW'(WR_CYC - 1);
            end else if (busy_reg) begin
                if (wcyc_reg == '0) begin
                    busy_reg <= 1'b0; // [R15]
                end else begin
                    wcyc_reg <= wcyc_reg - CW'(1);
                end
            end
        end
    end

    // array: erased at reset, written bytes of the page committed at once
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2**MEM_AW; i++) begin
                mem[i] <= EEPS_ERASED; // [R21]
            end
        end else if (commit) begin
            for (int i = 0; i < EEPS_PAGE_SIZE; i++) begin
                if (pmask_reg[i]) begin
                    mem[{page, 4'(i)}] <= pbuf[i]; // [R13]
                end
            end
        end
    end
endmodule // eeps_dev

// File: src/eeps_host.sv
// two-wire bus master: start, stop, byte write and byte read primitives
module eeps_host import eeps_pkg::*; #(
    parameter int QTR_CYC = EEPS_QTR_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    eeps_if.host bus,
    input wire logic cmd_valid,
    input wire eeps_cmd_t cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_nack,
    output logic cmd_ready,
    output logic done,
    output logic [7:0] rx_data,
    output logic ack_seen
);
    localparam int QW = $clog2(QTR_CYC);

    eeps_hst_t state_reg;
    logic [QW-1:0] qdiv_reg;
    logic [1:0] q_reg;
    logic [3:0] bit_reg;
    logic [7:0] tx_reg;
    logic rd_reg;
    logic nack_reg;
    logic scl_reg;
    logic oe_reg;
    logic ready_reg;
    logic done_reg;
    logic [7:0] rx_reg;
    logic ack_reg;
    logic sda_s1_reg;
    logic sda_s2_reg;

    // quarter tick, bit drive level and last-bit decode
    wire logic tick = (qdiv_reg == QW'(QTR_CYC - 1));
    wire logic last_bit = (bit_reg == EEPS_ACK_BIT);
    wire logic [2:0] tx_sel = 3'h7 - bit_reg[2:0];
    wire logic drive = last_bit ? (rd_reg & ~nack_reg) : (~rd_reg & ~tx_reg[tx_sel]); // [R10] [R06]

    assign bus.scl = scl_reg;
    assign bus.host_sda_oe = oe_reg;
    assign cmd_ready = ready_reg;
    assign done = done_reg;
    assign rx_data = rx_reg;
    assign ack_seen = ack_reg;

    // data line synchroniser
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
        end else begin
            sda_s1_reg <= bus.sda;
            sda_s2_reg <= sda_s1_reg;
        end
    end

    // command sequencer, each bit in four quarters of the divided clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= eeps_hs_idle;
            qdiv_reg <= '0;
            q_reg <= 2'h0;
            bit_reg <= 4'h0;
            tx_reg <= 8'h00;
            rd_reg <= 1'b0;
            nack_reg <= 1'b0;
            scl_reg <= 1'b1;
            oe_reg <= 1'b0;
            ready_reg <= 1'b1;
            done_reg <= 1'b0;
            rx_reg <= 8'h00;
            ack_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (state_reg == eeps_hs_idle) begin
                if (cmd_valid && ready_reg) begin
                    ready_reg <= 1'b0;
                    qdiv_reg <= '0;
                    q_reg <= 2'h0;
                    bit_reg <= 4'h0;
                    tx_reg <= cmd_data;
                    nack_reg <= cmd_nack;
                    rd_reg <= (cmd_op == eeps_cmd_read);
                    case (cmd_op)
                        eeps_cmd_start: state_reg <= eeps_hs_start;
                        eeps_cmd_stop: state_reg <= eeps_hs_stop;
                        default: state_reg <= eeps_hs_bit;
                    endcase
                end
            end else begin
                qdiv_reg <= tick ? '0 : qdiv_reg + QW'(1);
                if (tick) begin
                    q_reg <= q_reg + 2'h1;
                    case (state_reg)
                        eeps_hs_start: begin
                            case (q_reg)
                                2'h0: oe_reg <= 1'b0;
                                2'h1: scl_reg <= 1'b1;
                                2'h2: oe_reg <= 1'b1; // [R07] [R18]
                                default: begin
                                    scl_reg <= 1'b0;
                                    state_reg <= eeps_hs_idle;
                                    ready_reg <= 1'b1;
                                    done_reg <= 1'b1;
                                end
                            endcase
                        end
                        eeps_hs_stop: begin
                            case (q_reg)
                                2'h0: begin
                                    scl_reg <= 1'b0;
                                    oe_reg <= 1'b1;
                                end
                                2'h1: scl_reg <= 1'b1;
                                2'h2: oe_reg <= 1'b0; // [R07] [R11]
                                default: begin
                                    state_reg <= eeps_hs_idle;
                                    ready_reg <= 1'b1;
                                    done_reg <= 1'b1;
                                end
                            endcase
                        end
                        eeps_hs_bit: begin
                            case (q_reg)
                                2'h0: begin
                                    scl_reg <= 1'b0;
                                    oe_reg <= drive; // [R07]
                                end
                                2'h1: scl_reg <= 1'b1;
                                2'h2: scl_reg <= 1'b1;
                                default: begin
                                    scl_reg <= 1'b0;
                                    if (last_bit) begin
                                        ack_reg <= ~sda_s2_reg; // [R15]
                                        state_reg <= eeps_hs_idle;
                                        ready_reg <= 1'b1;
                                        done_reg <= 1'b1;
                                    end else begin
                                        rx_reg <= {rx_reg[6:0], sda_s2_reg};
                                        bit_reg <= bit_reg + 4'h1;
                                    end
                                end
                            endcase
                        end
                        default: state_reg <= eeps_hs_idle;
                    endcase
                end
            end
        end
    end
endmodule // eeps_host

// File: tb/eeps_monitor.sv
// concurrent checks on the two-wire link between the eeprom slave and its master
module eeps_monitor #(
    parameter int WR_CYC = 200
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic write_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl_reg, sda_reg, active_reg;
    logic [3:0] bit_reg;
    logic [1:0] byte_reg;
    logic [31:0] busy_reg;
    // bus events seen in the system clock domain
    wire scl_rise = scl && !scl_reg;
    wire start_ev = scl && scl_reg && sda_reg && !sda;
    wire stop_ev = scl && scl_reg && !sda_reg && sda;
    // bit and byte position within a frame, frame activity, busy length
    wire [3:0] bit_next = start_ev ? 4'h0 : !scl_rise ? bit_reg :
        (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
    wire [1:0] byte_next = start_ev ? 2'h0 :
        (scl_rise && bit_reg == 4'h8 && byte_reg != 2'h3) ? byte_reg + 2'h1 : byte_reg;
    wire active_next = start_ev ? 1'h1 : stop_ev ? 1'h0 : active_reg;
    wire [31:0] busy_next = write_busy ? busy_reg + 32'h0000_0001 : 32'h0000_0000;
    // helper state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_reg <= 1'h1;
            sda_reg <= 1'h1;
            active_reg <= 1'h0;
            bit_reg <= 4'h0;
            byte_reg <= 2'h0;
            busy_reg <= 32'h0000_0000;
        end else begin
            scl_reg <= scl;
            sda_reg <= sda;
            active_reg <= active_next;
            bit_reg <= bit_next;
            byte_reg <= byte_next;
            busy_reg <= busy_next;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // a driven bit is still driven when the clock next rises
    sequence s_ack_clocked;
        ##[1:40] (scl_rise && dev_sda_oe);
    endsequence
    property p_oe_scl_low;
        $changed(dev_sda_oe) |-> !scl;
    endproperty
    property p_oe_stable_high;
        scl && scl_reg |-> $stable(dev_sda_oe);
    endproperty
    property p_idle_silent;
        !active_reg |-> !dev_sda_oe;
    endproperty
    property p_busy_silent;
        write_busy |-> !dev_sda_oe;
    endproperty
    property p_busy_len;
        $fell(write_busy) |-> busy_reg == WR_CYC;
    endproperty
    property p_busy_at_idle;
        $rose(write_busy) |-> scl && sda;
    endproperty
    property p_ack_held;
        $rose(dev_sda_oe) |-> s_ack_clocked;
    endproperty
    property p_no_contend;
        scl_rise |-> !(dev_sda_oe && host_sda_oe);
    endproperty
    property p_addr_ack_slot;
        scl_rise && dev_sda_oe && byte_reg == 2'h0 |-> bit_reg == 4'h8;
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("slave data output changed while clock high");
    a_oe_stable_high: assert property (p_oe_stable_high)
        else $error("slave data output moved during clock high");
    a_idle_silent: assert property (p_idle_silent)
        else $error("slave drove data outside a frame");
    a_busy_silent: assert property (p_busy_silent)
        else $error("slave drove data during internal write");
    a_busy_len: assert property (p_busy_len)
        else $error("internal write length wrong");
    a_busy_at_idle: assert property (p_busy_at_idle)
        else $error("internal write began with bus not idle");
    a_ack_held: assert property (p_ack_held)
        else $error("slave low level not held to clock rise");
    a_no_contend: assert property (p_no_contend)
        else $error("both ends drove data at clock rise");
    a_addr_ack_slot: assert property (p_addr_ack_slot)
        else $error("address byte answered outside ninth period");
endmodule // eeps_monitor

// File: tb/test_i2c_serial_eeprom_slave.sv
// self-checking bench: master and eeprom slave joined over the two-wire link
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin errors++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); end end
module test_i2c_serial_eeprom_slave import eeps_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WRC = 1000;
    logic sys_clk = 1'h0;
    logic rst = 1'h0;
    logic wp = 1'h0;
    logic cmd_valid = 1'h0;
    eeps_cmd_t cmd_op = eeps_cmd_start;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_nack = 1'h0;
    logic cmd_ready, done, ack_seen, write_busy;
    logic [7:0] rx_data;
    int errors = 0;
    int tests_run = 0;
    eeps_if link ();
    eeps_dev #(.MEM_AW(11), .WR_CYC(WRC)) eeps_dev_i (.sys_clk(sys_clk), .rst(rst),
        .bus(link), .addr_select_pin0(1'h0), .addr_select_pin1(1'h0),
        .addr_select_pin2(1'h0), .wp(wp), .write_busy(write_busy));
    eeps_host #(.QTR_CYC(5)) eeps_host_i (.sys_clk(sys_clk), .rst(rst), .bus(link),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
        .cmd_ready(cmd_ready), .done(done), .rx_data(rx_data), .ack_seen(ack_seen));
    eeps_monitor #(.WR_CYC(WRC)) eeps_monitor_i (.sys_clk(sys_clk), .rst(rst),
        .scl(link.scl), .sda(link.sda), .host_sda_oe(link.host_sda_oe),
        .dev_sda_oe(link.dev_sda_oe), .write_busy(write_busy));
    // system clock, 50 ns period
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // one master command, waited for under a bounded count
    task automatic cmd(input eeps_cmd_t op, input logic [7:0] data, input logic nack);
        int n;
        @(posedge sys_clk);
        #1 cmd_valid = 1'h1;
        cmd_op = op;
        cmd_data = data;
        cmd_nack = nack;
        @(posedge sys_clk);
        #1 cmd_valid = 1'h0;
        n = 0;
        while (done !== 1'h1 && n < 400) begin
            @(posedge sys_clk);
            #1 n++;
        end
        `CHK("done and ready", 2'h3, {done, cmd_ready})
    endtask
    task automatic st();
        cmd(eeps_cmd_start, 8'h00, 1'h0);
    endtask
    task automatic sp();
        cmd(eeps_cmd_stop, 8'h00, 1'h0);
    endtask
    task automatic wr(input logic [7:0] b, input logic exp_ack);
        cmd(eeps_cmd_write, b, 1'h0);
        `CHK("ack", exp_ack, ack_seen)
    endtask
    task automatic rd(input logic nack, input logic [7:0] exp);
        cmd(eeps_cmd_read, 8'h00, nack);
        `CHK("read data", exp, rx_data)
    endtask
    // start, write address, byte address: loads the pointer
    task automatic set_ptr(input logic [10:0] a);
        st();
        wr({EEPS_PREFIX, a[10:8], 1'h0}, 1'h1);
        wr(a[7:0], 1'h1);
    endtask
    // repeated start and read-direction address after a pointer load
    task automatic restart_rd(input logic [10:0] a);
        set_ptr(a);
        st();
        wr({EEPS_PREFIX, a[10:8], 1'h1}, 1'h1);
    endtask
    // busy level right after stop, then wait for the write to end
    task automatic wait_write(input logic exp_busy);
        int n;
        `CHK("write busy", exp_busy, write_busy)
        n = 0;
        while (write_busy !== 1'h0 && n < WRC + 20) begin
            @(posedge sys_clk);
            #1 n++;
        end
    endtask
    task automatic done_test(input string name);
        $display("test %s finished, %0d checks, %0d errors", name, tests_run, errors);
    endtask
    task automatic end_of_test();
        $display("%0d checks made, %0d errors", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge sys_clk);
        errors++;
        $display("ERROR watchdog expected end seen timeout");
        end_of_test();
    end
    // test sequence
    initial begin
        // a real rising reset edge, so the asynchronous resets take effect
        #1 rst = 1'h1;
        repeat (20) @(posedge sys_clk);
        #1 rst = 1'h0;
        // immediate read of a fresh device
        st();
        wr({EEPS_PREFIX, 3'h0, 1'h1}, 1'h1);
        rd(1'h1, EEPS_ERASED);
        sp();
        done_test("immediate read");
        // foreign prefix is ignored
        st();
        wr(8'hb0, 1'h0);
        sp();
        done_test("prefix");
        // byte write, then polling while busy and after
        set_ptr(11'h000);
        wr(8'h5a, 1'h1);
        sp();
        st();
        wr({EEPS_PREFIX, 3'h0, 1'h0}, 1'h0);
        sp();
        wait_write(1'h1);
        st();
        wr({EEPS_PREFIX, 3'h0, 1'h0}, 1'h1);
        sp();
        done_test("byte write and polling");
        // seventeen bytes from offset 14 wrap inside the page
        set_ptr(11'h12e);
        for (int i = 0; i < 17; i++) begin
            wr(8'(8'h30 + i), 1'h1);
        end
        sp();
        wait_write(1'h1);
        restart_rd(11'h120);
        for (int k = 0; k < 17; k++) begin
            rd(1'(k == 16), k < 14 ? 8'(8'h32 + k) : k == 14 ? 8'h40 :
                k == 15 ? 8'h31 : EEPS_ERASED);
        end
        sp();
        done_test("page write wrap");
        // sequential read wraps at memory end, block bits select memory
        restart_rd(11'h7ff);
        rd(1'h0, EEPS_ERASED);
        rd(1'h1, 8'h5a);
        sp();
        restart_rd(11'h300);
        rd(1'h1, EEPS_ERASED);
        sp();
        done_test("read wrap and block");
        // protected write is refused and leaves memory intact
        wp = 1'h1;
        set_ptr(11'h000);
        wr(8'ha5, 1'h0);
        sp();
        wait_write(1'h0);
        wp = 1'h0;
        restart_rd(11'h000);
        rd(1'h1, 8'h5a);
        sp();
        done_test("write protect");
        // reset mid-run restores the erased array and pointer zero
        rst = 1'h1;
        repeat (2) @(posedge sys_clk);
        #1 rst = 1'h0;
        st();
        wr({EEPS_PREFIX, 3'h0, 1'h1}, 1'h1);
        rd(1'h1, EEPS_ERASED);
        sp();
        done_test("reset");
        end_of_test();
    end
endmodule // test_i2c_serial_eeprom_slave
